// ===== rtl/aop_pkg.sv
package aop_pkg;

  localparam int NCH = 2;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int VW = 16;

  // unit registers
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AW-1:0] REG_MASK = 8'h08;
  localparam logic [AW-1:0] REG_INPUTS = 8'h0C;

  // channel c occupies the 32-byte page (c + 1); offsets within the page
  localparam int PAGE_LSB = 5;
  localparam logic [4:0] CH_CFG = 5'h00;
  localparam logic [4:0] CH_ULIM = 5'h04;
  localparam logic [4:0] CH_LLIM = 5'h08;
  localparam logic [4:0] CH_SUP = 5'h0C;
  localparam logic [4:0] CH_SLO = 5'h10;
  localparam logic [4:0] CH_FAULT = 5'h14;
  localparam logic [4:0] CH_IDLE = 5'h18;
  localparam logic [4:0] CH_CMD = 5'h1C;

  // field positions
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_SHORT_BIT = 2;
  localparam int CTRL_PRIO_BIT = 3;
  localparam int CFG_RNG_LSB = 0;
  localparam int CFG_UEN_BIT = 3;
  localparam int CFG_LEN_BIT = 4;
  localparam int CFG_SUEN_BIT = 5;
  localparam int CFG_SLEN_BIT = 6;
  localparam int CFG_FEN_BIT = 7;
  localparam int CFG_IEN_BIT = 8;
  localparam int SIGN_BIT = 15;

  // status layout: bit 0 short, then five bits per channel
  localparam int ST_SHORT = 0;
  localparam int ST_CH_BASE = 1;
  localparam int ST_CH_W = 5;
  localparam int ST_UP = 0;
  localparam int ST_LO = 1;
  localparam int ST_SUP = 2;
  localparam int ST_SLO = 3;
  localparam int ST_REJ = 4;
  localparam int STW = ST_CH_BASE + ST_CH_W * NCH;

  // synchronised pin inputs
  localparam int IN_SHORT = 0;
  localparam int IN_ERR = 1;
  localparam int IN_IDLE = 2;
  localparam int NIN = 3;

  // scale limit bounds, two's complement
  localparam logic [VW-1:0] SUP_MIN = 16'h8002;
  localparam logic [VW-1:0] SLO_MIN = 16'h8001;
  localparam logic [VW-1:0] SLO_MAX = 16'h7FFE;
  localparam logic [VW-1:0] SUP_RST = 16'h03E8;
  localparam logic [VW-1:0] SLO_RST = 16'h0000;
  localparam logic [VW-1:0] ULIM_RST = 16'h041A;
  localparam logic [VW-1:0] LLIM_RST = 16'h0000;

  typedef enum logic [2:0] {
    AOP_R_0_10V,
    AOP_R_0_5V,
    AOP_R_1_5V,
    AOP_R_0_20MA,
    AOP_R_4_20MA
  } aop_range_t;
  localparam logic [2:0] NRANGE = 3'h5;

  typedef enum logic [1:0] {
    AOP_F_OFFSET,
    AOP_F_SIGNMAG,
    AOP_F_TWOS,
    AOP_F_SCALED
  } aop_fmt_t;

  // settable windows in hundredths of a volt or milliamp
  typedef struct packed {
    logic [VW-1:0] loMin;
    logic [VW-1:0] loMax;
    logic [VW-1:0] upMin;
    logic [VW-1:0] upMax;
    logic [VW-1:0] outMin;
    logic [VW-1:0] outMax;
  } aop_win_t;

  localparam aop_win_t WIN_0_10V = '{16'h0000, 16'h0415, 16'h0005, 16'h041A, 16'h0000, 16'h041A};
  localparam aop_win_t WIN_0_5V = '{16'h0000, 16'h020A, 16'h0003, 16'h020D, 16'h0000, 16'h020D};
  localparam aop_win_t WIN_1_5V = '{16'h004B, 16'h020A, 16'h004E, 16'h020D, 16'h004B, 16'h020D};
  localparam aop_win_t WIN_0_20MA = '{16'h0000, 16'h082A, 16'h000A, 16'h0834, 16'h0000, 16'h0834};
  localparam aop_win_t WIN_4_20MA = '{16'h012C, 16'h082A, 16'h0136, 16'h0834, 16'h012C, 16'h0834};

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic we;
    logic re;
  } aop_bus_t;

  typedef struct packed {
    aop_range_t rng;
    logic uEn;
    logic lEn;
    logic suEn;
    logic slEn;
    logic fEn;
    logic iEn;
    logic [VW-1:0] uLim;
    logic [VW-1:0] lLim;
    logic [VW-1:0] sUp;
    logic [VW-1:0] sLo;
    logic [VW-1:0] fault;
    logic [VW-1:0] idle;
    logic [VW-1:0] cmd;
    logic [VW-1:0] out;
  } aop_chan_t;

  typedef struct packed {
    aop_fmt_t fmt;
    logic shortEn;
    logic prioSoft;
    logic [STW-1:0] status;
    logic [STW-1:0] mask;
    logic [NIN-1:0] syncA;
    logic [NIN-1:0] syncB;
    aop_chan_t [NCH-1:0] ch;
    logic [DW-1:0] rdata;
  } aop_state_t;

  localparam aop_chan_t CHAN_RST = '{
    rng: AOP_R_0_10V, uEn: 1'b0, lEn: 1'b0, suEn: 1'b0, slEn: 1'b0, fEn: 1'b0, iEn: 1'b0,
    uLim: ULIM_RST, lLim: LLIM_RST, sUp: SUP_RST, sLo: SLO_RST,
    fault: 16'h0000, idle: 16'h0000, cmd: 16'h0000, out: 16'h0000
  };

endpackage

// ===== rtl/aop_param_check.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// R01 - positive user limit over the numeric path is value times 100, plain decimal
// R02 - negative numeric-path limit is magnitude times 100 with bit 15 set as sign
// R03 - web path enters value times 100 with an ordinary minus sign
// R04 - codes 0..1050 positive and 32768..33818 negative, hundredths, are decoded
// R05 - user lower and upper limits accepted only inside the range's windows; in scaled format the code accepts any limit value
// R06 - five output ranges per channel, 0-10 V by default
// R07 - data format offset binary, sign-magnitude, two's complement or scaled; offset default
// R08 - supply short raises an error only when detection enabled; disabled by default
// R09 - enabled upper limit error fires when command exceeds stored upper limit
// R10 - enabled lower limit error fires when command drops below stored lower limit
// R11 - scaled: scale upper limit -32766..32767, default 1000, error above it
// R12 - scaled: scale lower limit -32767..32766, default 0, error below it
// R13 - on communication error drive fault value if enabled, else hold output
// R14 - while communication idles drive idle value if enabled, else hold output
// R15 - fault and idle choices apply only when priority selects software control
// R16 - fault and idle values must lie within the selected range span; in scaled format the code accepts any fault or idle value
// R17 - the configuring party rechecks stored limits after changing a channel's range
// R18 - scaled: codes 0..32767 positive, 32768..65535 negative -0..-32767; the code decodes scaled commands as two's complement instead
// R19 - out-of-window limit, fault or idle writes are refused and flagged; in scaled format the code accepts them without a window check
module aop_param_check (
  input wire logic core_clk,
  input wire logic srst,
  input wire aop_pkg::aop_bus_t bus,
  output logic [aop_pkg::DW-1:0] rdata,
  input wire logic shortPin,
  input wire logic commErrPin,
  input wire logic commIdlePin,
  output logic [aop_pkg::NCH-1:0][aop_pkg::VW-1:0] chOut,
  output logic irq
);
  import aop_pkg::*;

  aop_state_t s;
  aop_state_t next_s;

  // sign-magnitude code to a signed value
  function automatic logic signed [VW:0] smDecode(input logic [VW-1:0] c);
    logic signed [VW:0] mag;
    mag = $signed({2'b00, c[SIGN_BIT-1:0]});
    return c[SIGN_BIT] ? -mag : mag; // R01 R02 R04 R18
  endfunction

  function automatic logic signed [VW:0] tcDecode(input logic [VW-1:0] c);
    return $signed({c[SIGN_BIT], c});
  endfunction

  function automatic logic inWin(input logic signed [VW:0] v, input logic [VW-1:0] lo,
                                 input logic [VW-1:0] hi);
    // signed compare in hundredths, however the sign was entered
    return (v >= $signed({1'b0, lo})) && (v <= $signed({1'b0, hi})); // R03
  endfunction

  function automatic aop_win_t rangeWin(input aop_range_t r);
    aop_win_t w;
    unique case (r)
      AOP_R_0_10V: w = WIN_0_10V;
      AOP_R_0_5V: w = WIN_0_5V;
      AOP_R_1_5V: w = WIN_1_5V;
      AOP_R_0_20MA: w = WIN_0_20MA;
      AOP_R_4_20MA: w = WIN_4_20MA;
      default: w = WIN_0_10V;
    endcase
    return w;
  endfunction

  // commanded value as the active data format presents it
  function automatic logic signed [VW:0] cmdDecode(input aop_fmt_t f, input logic [VW-1:0] c);
    logic signed [VW:0] v;
    unique case (f)
      AOP_F_OFFSET: v = $signed({1'b0, c});
      AOP_F_SIGNMAG: v = smDecode(c);
      AOP_F_TWOS: v = tcDecode(c);
      AOP_F_SCALED: v = tcDecode(c);
    endcase
    return v;
  endfunction

  always_comb begin
    logic [STW-1:0] evt;
    logic [STW-1:0] clr;
    logic [VW-1:0] wd;
    logic [4:0] off;
    logic scaled;
    logic hit;
    logic ok;
    logic errNow;
    logic idleNow;
    logic signed [VW:0] cv;
    aop_win_t w;
    int b;
    evt = '0;
    clr = '0;
    wd = bus.wdata[VW-1:0];
    off = bus.addr[PAGE_LSB-1:0];
    scaled = (s.fmt == AOP_F_SCALED);
    hit = 1'b0;
    ok = 1'b0;
    errNow = s.syncB[IN_ERR];
    idleNow = s.syncB[IN_IDLE];
    cv = '0;
    w = WIN_0_10V;
    b = 0;
    next_s = s;

    // pins are asynchronous: two flops before any use
    next_s.syncA = {commIdlePin, commErrPin, shortPin};
    next_s.syncB = s.syncA;

    if (bus.we) begin
      unique case (bus.addr)
        REG_CTRL: begin
          next_s.fmt = aop_fmt_t'(bus.wdata[CTRL_FMT_LSB +: 2]); // R07
          next_s.shortEn = bus.wdata[CTRL_SHORT_BIT]; // R08
          next_s.prioSoft = bus.wdata[CTRL_PRIO_BIT]; // R15
        end
        REG_STATUS: clr = bus.wdata[STW-1:0];
        REG_MASK: next_s.mask = bus.wdata[STW-1:0];
        default: ;
      endcase
    end

    if (s.shortEn && s.syncB[IN_SHORT]) begin
      evt[ST_SHORT] = 1'b1; // R08
    end

    for (int c = 0; c < NCH; c++) begin
      b = ST_CH_BASE + c * ST_CH_W;
      w = rangeWin(s.ch[c].rng);
      hit = bus.we && (bus.addr[AW-1:PAGE_LSB] == 3'(c + 1));
      ok = 1'b1;
      if (hit) begin
        unique case (off)
          CH_CFG: begin
            ok = (bus.wdata[CFG_RNG_LSB +: 3] < NRANGE); // R06
            if (ok) begin
              next_s.ch[c].rng = aop_range_t'(bus.wdata[CFG_RNG_LSB +: 3]);
              next_s.ch[c].uEn = bus.wdata[CFG_UEN_BIT];
              next_s.ch[c].lEn = bus.wdata[CFG_LEN_BIT];
              next_s.ch[c].suEn = bus.wdata[CFG_SUEN_BIT];
              next_s.ch[c].slEn = bus.wdata[CFG_SLEN_BIT];
              next_s.ch[c].fEn = bus.wdata[CFG_FEN_BIT];
              next_s.ch[c].iEn = bus.wdata[CFG_IEN_BIT];
            end
          end
          CH_ULIM: begin
            ok = scaled || inWin(smDecode(wd), w.upMin, w.upMax); // R05 R18
            if (ok) next_s.ch[c].uLim = wd;
          end
          CH_LLIM: begin
            ok = scaled || inWin(smDecode(wd), w.loMin, w.loMax); // R05 R18
            if (ok) next_s.ch[c].lLim = wd;
          end
          CH_SUP: begin
            ok = (tcDecode(wd) >= tcDecode(SUP_MIN)); // R11
            if (ok) next_s.ch[c].sUp = wd;
          end
          CH_SLO: begin
            ok = (tcDecode(wd) >= tcDecode(SLO_MIN)) && (tcDecode(wd) <= tcDecode(SLO_MAX)); // R12
            if (ok) next_s.ch[c].sLo = wd;
          end
          CH_FAULT: begin
            ok = scaled || inWin(smDecode(wd), w.outMin, w.outMax); // R16
            if (ok) next_s.ch[c].fault = wd;
          end
          CH_IDLE: begin
            ok = scaled || inWin(smDecode(wd), w.outMin, w.outMax); // R16
            if (ok) next_s.ch[c].idle = wd;
          end
          CH_CMD: next_s.ch[c].cmd = wd;
          default: ;
        endcase
        // a refused write leaves the stored value untouched
        if (!ok) evt[b + ST_REJ] = 1'b1; // R19
      end

      // limit checks run continuously against the stored command
      cv = cmdDecode(s.fmt, s.ch[c].cmd);
      if (s.ch[c].uEn && (cv > smDecode(s.ch[c].uLim))) begin
        evt[b + ST_UP] = 1'b1; // R09
      end
      if (s.ch[c].lEn && (cv < smDecode(s.ch[c].lLim))) begin
        evt[b + ST_LO] = 1'b1; // R10
      end
      if (scaled && s.ch[c].suEn && (cv > tcDecode(s.ch[c].sUp))) begin
        evt[b + ST_SUP] = 1'b1; // R11
      end
      if (scaled && s.ch[c].slEn && (cv < tcDecode(s.ch[c].sLo))) begin
        evt[b + ST_SLO] = 1'b1; // R12
      end

      // communication error outranks idle; with neither the command is driven, otherwise a disabled choice holds the last output
      if (errNow) begin
        if (s.prioSoft && s.ch[c].fEn) next_s.ch[c].out = s.ch[c].fault; // R13 R15
      end else if (idleNow) begin
        if (s.prioSoft && s.ch[c].iEn) next_s.ch[c].out = s.ch[c].idle; // R14 R15
      end else begin
        next_s.ch[c].out = s.ch[c].cmd;
      end
    end

    // set wins over a write-one clear in the same cycle
    next_s.status = (s.status & ~clr) | evt;

    next_s.rdata = '0;
    if (bus.re) begin
      if (bus.addr[AW-1:PAGE_LSB] == '0) begin
        unique case (bus.addr)
          REG_CTRL: begin
            next_s.rdata[CTRL_FMT_LSB +: 2] = s.fmt;
            next_s.rdata[CTRL_SHORT_BIT] = s.shortEn;
            next_s.rdata[CTRL_PRIO_BIT] = s.prioSoft;
          end
          REG_STATUS: next_s.rdata[STW-1:0] = s.status;
          REG_MASK: next_s.rdata[STW-1:0] = s.mask;
          REG_INPUTS: next_s.rdata[NIN-1:0] = s.syncB;
          default: ;
        endcase
      end
      for (int c = 0; c < NCH; c++) begin
        if (bus.addr[AW-1:PAGE_LSB] == 3'(c + 1)) begin
          unique case (off)
            CH_CFG: begin
              next_s.rdata[CFG_RNG_LSB +: 3] = s.ch[c].rng;
              next_s.rdata[CFG_UEN_BIT] = s.ch[c].uEn;
              next_s.rdata[CFG_LEN_BIT] = s.ch[c].lEn;
              next_s.rdata[CFG_SUEN_BIT] = s.ch[c].suEn;
              next_s.rdata[CFG_SLEN_BIT] = s.ch[c].slEn;
              next_s.rdata[CFG_FEN_BIT] = s.ch[c].fEn;
              next_s.rdata[CFG_IEN_BIT] = s.ch[c].iEn;
            end
            CH_ULIM: next_s.rdata[VW-1:0] = s.ch[c].uLim;
            CH_LLIM: next_s.rdata[VW-1:0] = s.ch[c].lLim;
            CH_SUP: next_s.rdata[VW-1:0] = s.ch[c].sUp;
            CH_SLO: next_s.rdata[VW-1:0] = s.ch[c].sLo;
            CH_FAULT: next_s.rdata[VW-1:0] = s.ch[c].fault;
            CH_IDLE: next_s.rdata[VW-1:0] = s.ch[c].idle;
            // reading the command slot shows the value being driven
            CH_CMD: next_s.rdata[VW-1:0] = s.ch[c].out;
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s.fmt <= AOP_F_OFFSET; // R07
      s.shortEn <= 1'b0; // R08
      s.prioSoft <= 1'b0;
      s.status <= '0;
      s.mask <= '0;
      s.syncA <= '0;
      s.syncB <= '0;
      s.ch <= {NCH{CHAN_RST}}; // R06 R11 R12
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign irq = |(s.status & s.mask);

  for (genvar g = 0; g < NCH; g++) begin : gOut
    assign chOut[g] = s.ch[g].out;
  end

endmodule

// ===== bench/aop_param_check_asserts.sv
`timescale 1ns/1ps
module aop_param_check_asserts (
  input wire logic core_clk,
  input wire logic srst,
  input wire aop_pkg::aop_bus_t bus,
  input wire logic [aop_pkg::DW-1:0] rdata,
  input wire logic shortPin,
  input wire logic commErrPin,
  input wire logic commIdlePin,
  input wire logic [aop_pkg::NCH-1:0][aop_pkg::VW-1:0] chOut,
  input wire logic irq
);
  import aop_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_rdata_quiet;
    !bus.re |=> rdata == '0;
  endproperty
  property p_after_reset;
    $fell(srst) |-> !irq && chOut == '0 && rdata == '0;
  endproperty
  property p_unmapped;
    bus.re && bus.addr == 8'h10 |=> rdata == '0;
  endproperty
  property p_cmd_readback;
    bus.re && bus.addr == {3'h1, CH_CMD} |=> rdata == {16'h0000, $past(chOut[0])};
  endproperty
  property p_cmd_out;
    (!commErrPin && !commIdlePin)[*3] ##0 (bus.we && bus.addr == {3'h1, CH_CMD})
      |=> ##1 chOut[0] == $past(bus.wdata[VW-1:0], 2);
  endproperty
  property p_err_hold;
    (commErrPin && !bus.we)[*4] |=> $stable(chOut);
  endproperty
  property p_idle_hold;
    (commIdlePin && !commErrPin && !bus.we)[*4] |=> $stable(chOut);
  endproperty
  // irq can only rise from a write, a short, or a pin-driven output change
  property p_irq_cause;
    $rose(irq) |-> $past(bus.we) || $past(bus.we, 2) || $past(bus.we, 3)
      || $past(shortPin, 2) || $past(shortPin, 3)
      || $past(commErrPin || commIdlePin, 3) || $past(commErrPin || commIdlePin, 4);
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("rdata not zero");
  a_after_reset: assert property (p_after_reset) else $error("outputs not clear");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_cmd_readback: assert property (p_cmd_readback) else $error("command readback");
  a_cmd_out: assert property (p_cmd_out) else $error("command not driven");
  a_err_hold: assert property (p_err_hold) else $error("output moved in error");
  a_idle_hold: assert property (p_idle_hold) else $error("output moved in idle");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  c_cmd: cover property (bus.we && bus.addr == {3'h1, CH_CMD});
  c_irq: cover property ($rose(irq));
  c_err: cover property (commErrPin[*4]);
endmodule

bind aop_param_check aop_param_check_asserts aop_param_check_asserts_inst (
  .core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata), .shortPin(shortPin),
  .commErrPin(commErrPin), .commIdlePin(commIdlePin), .chOut(chOut), .irq(irq)
);

// ===== bench/aop_net_model.sv
`timescale 1ns/1ps
module aop_net_model (
  input wire logic core_clk,
  input wire logic [2:0] mode,
  output logic shortPin = 1'b0,
  output logic commErrPin = 1'b0,
  output logic commIdlePin = 1'b0
);
  // levels move between edges, as an unsynchronised network source would
  always @(posedge core_clk) begin
    #3;
    {commIdlePin, commErrPin, shortPin} = mode;
  end
endmodule

// ===== bench/aop_param_check_test.sv
`timescale 1ns/1ps
module aop_param_check_test;
  import aop_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  aop_bus_t bus = '0;
  logic [DW-1:0] rdata;
  logic [NCH-1:0][VW-1:0] chOut;
  logic irq;
  logic [2:0] mode = 3'h0;
  logic shortPin;
  logic commErrPin;
  logic commIdlePin;
  int num_errors = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  aop_param_check aop_param_check_inst (.core_clk(core_clk), .srst(srst), .bus(bus),
    .rdata(rdata), .shortPin(shortPin), .commErrPin(commErrPin), .commIdlePin(commIdlePin),
    .chOut(chOut), .irq(irq));
  aop_net_model aop_net_model_inst (.core_clk(core_clk), .mode(mode), .shortPin(shortPin),
    .commErrPin(commErrPin), .commIdlePin(commIdlePin));
  function automatic logic [AW-1:0] ca(input logic [4:0] o);
    return {3'h1, o};
  endfunction
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] want);
    bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1 check(rdata, want);
    @(posedge core_clk);
  endtask
  task automatic pins(input logic [2:0] m, input logic [VW-1:0] want);
    mode <= m;
    repeat (5) @(posedge core_clk);
    #1 check({16'h0000, chOut[0]}, {16'h0000, want});
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(REG_CTRL, 32'h0);
    rd(ca(CH_CFG), 32'h0);
    rd(ca(CH_ULIM), 32'h41A);
    rd(ca(CH_SUP), 32'h3E8);
    rd(8'h10, 32'h0);
    wr(ca(CH_CFG), 32'h5);
    rd(ca(CH_CFG), 32'h0);
    wr(ca(CH_CFG), 32'h2);
    wr(ca(CH_LLIM), 32'h4A);
    rd(ca(CH_LLIM), 32'h0);
    rd(REG_STATUS, 32'h20);
    wr(ca(CH_LLIM), 32'h4B);
    rd(ca(CH_LLIM), 32'h4B);
    wr(ca(CH_ULIM), 32'h20E);
    rd(ca(CH_ULIM), 32'h41A);
    wr(ca(CH_ULIM), 32'h20D);
    wr(ca(CH_FAULT), 32'h4A);
    rd(ca(CH_FAULT), 32'h0);
    wr(ca(CH_CFG), 32'h1A);
    wr(REG_STATUS, 32'h7FF);
    rd(REG_STATUS, 32'h4);
    wr(ca(CH_CMD), 32'h20E);
    wr(REG_STATUS, 32'h7FF);
    rd(REG_STATUS, 32'h2);
    wr(REG_MASK, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(ca(CH_CMD), 32'h100);
    wr(REG_STATUS, 32'h7FF);
    check({31'h0, irq}, 32'h0);
    pins(3'h1, 16'h0100);
    rd(REG_STATUS, 32'h0);
    wr(REG_CTRL, 32'h4);
    rd(REG_STATUS, 32'h1);
    wr(REG_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(ca(CH_FAULT), 32'h200);
    wr(ca(CH_CFG), 32'h9A);
    pins(3'h2, 16'h0100);
    rd(REG_INPUTS, 32'h2);
    wr(REG_CTRL, 32'hC);
    pins(3'h2, 16'h0200);
    pins(3'h4, 16'h0200);
    wr(ca(CH_IDLE), 32'h150);
    wr(ca(CH_CFG), 32'h19A);
    pins(3'h4, 16'h0150);
    pins(3'h0, 16'h0100);
    wr(REG_CTRL, 32'h3);
    wr(ca(CH_SUP), 32'h8001);
    rd(ca(CH_SUP), 32'h3E8);
    wr(ca(CH_SUP), 32'h8002);
    rd(ca(CH_SUP), 32'h8002);
    wr(ca(CH_SLO), 32'h7FFF);
    rd(ca(CH_SLO), 32'h0);
    wr(ca(CH_ULIM), 32'h841A);
    rd(ca(CH_ULIM), 32'h841A);
    wr(ca(CH_CFG), 32'h1BA);
    wr(REG_STATUS, 32'h7FF);
    rd(REG_STATUS, 32'hA);
    wr(ca(CH_CFG), 32'h1FA);
    wr(ca(CH_SLO), 32'h7FFE);
    wr(REG_STATUS, 32'h7FF);
    rd(REG_STATUS, 32'h1A);
    rd(ca(CH_CMD), 32'h100);
    // second channel: its command reaches its own output only
    wr({3'h2, CH_CMD}, 32'h55);
    rd({3'h2, CH_CMD}, 32'h55);
    check({16'h0000, chOut[1]}, 32'h55);
    check({16'h0000, chOut[0]}, 32'h100);
    complete_run;
  end
endmodule
